// ==== logic/ign_seq_pkg.sv ====
package ign_seq_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BAUD         = 9600;
  localparam int unsigned BAUD_DIV     = CLK_HZ / BAUD;
  // 3.5 character times of 11 bits at 9600 baud
  localparam int unsigned T35_US       = 4010;
  localparam int unsigned T35_CYCLES   = T35_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYCLES  = TICK_MS * (CLK_HZ / 1000);
  localparam int unsigned MAIN_DELAY_S = 10;
  localparam int unsigned MAIN_TICKS   = MAIN_DELAY_S * 1000 / TICK_MS;

  localparam logic [7:0]  DEF_SLAVE_ADDR = 8'h02;
  localparam logic [7:0]  MB_FN_READ     = 8'h03;
  localparam logic [7:0]  MB_RD_BYTES    = 8'h02;
  localparam logic [3:0]  RX_LEN         = 4'h8;
  localparam logic [2:0]  TX_LAST        = 3'h6;
  localparam logic [2:0]  TX_CRC_FIRST   = 3'h5;

  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_INT_STS    = 12'h008;
  localparam logic [11:0] OFS_INT_MASK   = 12'h00C;
  localparam logic [11:0] OFS_SLAVE_ADDR = 12'h010;
  localparam logic [2:0]  SEL_NONE       = 3'h7;

  localparam int INT_W       = 5;
  localparam int EV_CLOSURE  = 0;
  localparam int EV_SHUTDOWN = 1;
  localparam int EV_ALARM    = 2;
  localparam int EV_MAIN_ON  = 3;
  localparam int EV_MB_REPLY = 4;
  localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PILOT, SEQ_WAIT, SEQ_RUN} seq_state_t;
  typedef enum logic [2:0] {
    DISP_RUN, DISP_OFF, DISP_REMOTE, DISP_LEVEL, DISP_SHUTDOWN,
    DISP_CLOSURE, DISP_TEMP, DISP_FLAME
  } disp_code_t;

  // high means closed / permissive
  typedef struct packed {
    logic on_off;
    logic remote_on;
    logic level_ok;
    logic shutdown_ok;
    logic closure_proof_switch;
    logic temp1_ok;
    logic temp2_ok;
  } perm_t;

  typedef struct packed {
    logic pilot;
    logic main_v;
    logic tmain;
  } sol_t;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ==== logic/uart_8n1.sv ====
`timescale 1ns/10ps
module uart_8n1 #(
  parameter int unsigned DIV = 10416
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // line side
  input  wire logic       rx_in,
  output logic            tx_out,
  output logic            tx_oe,
  // byte side
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic        rx_busy_r;
  logic [3:0]  rx_bit_r;
  logic [31:0] rx_cnt_r;
  logic [7:0]  rx_sh_r;
  logic [9:0]  tx_sh_r;
  logic [3:0]  tx_bits_r;
  logic [31:0] tx_cnt_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_busy_r <= 1'b0;
      rx_bit_r  <= 4'h0;
      rx_cnt_r  <= 32'h0;
      rx_sh_r   <= 8'h00;
      rx_valid  <= 1'b0;
      rx_data   <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_in) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= DIV / 2;
          rx_bit_r  <= 4'h0;
        end
      end else if (rx_cnt_r != 32'h0) begin
        rx_cnt_r <= rx_cnt_r - 32'h1;
      end else begin
        rx_cnt_r <= DIV - 1;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          if (rx_in) rx_busy_r <= 1'b0;
        end else if (rx_bit_r < 4'h9) begin
          rx_sh_r <= {rx_in, rx_sh_r[7:1]};
        end else begin
          // stop bit must read high
          rx_busy_r <= 1'b0;
          rx_valid  <= rx_in;
          rx_data   <= rx_sh_r;
        end
      end
    end
  end

  assign tx_ready = (tx_bits_r == 4'h0);
  assign tx_out   = tx_sh_r[0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_sh_r   <= 10'h3FF;
      tx_bits_r <= 4'h0;
      tx_cnt_r  <= 32'h0;
      tx_oe     <= 1'b0;
    end else if (tx_ready) begin
      tx_oe <= 1'b0;
      if (tx_valid) begin
        tx_sh_r   <= {1'b1, tx_data, 1'b0};
        tx_bits_r <= 4'hA;
        tx_cnt_r  <= DIV - 1;
        tx_oe     <= 1'b1;
      end
    end else if (tx_cnt_r != 32'h0) begin
      tx_cnt_r <= tx_cnt_r - 32'h1;
    end else begin
      tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
      tx_bits_r <= tx_bits_r - 4'h1;
      tx_cnt_r  <= DIV - 1;
    end
  end

  property p_tx_start;
    @(posedge clk) disable iff (!rstn)
    tx_valid && tx_ready |=> tx_oe && !tx_out && !tx_ready;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start bit not driven");
endmodule

// ==== logic/burner_ignition_sequencer.sv ====
`timescale 1ns/10ps
module burner_ignition_sequencer
  import ign_seq_pkg::*;
#(
  parameter int unsigned MAIN_TICKS_P  = ign_seq_pkg::MAIN_TICKS,
  parameter int unsigned TICK_CYCLES_P = ign_seq_pkg::TICK_CYCLES,
  parameter int unsigned BAUD_DIV_P    = ign_seq_pkg::BAUD_DIV,
  parameter int unsigned T35_CYCLES_P  = ign_seq_pkg::T35_CYCLES
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    irq,
  // permissives and switches
  input  wire ign_seq_pkg::perm_t perm,
  input  wire logic               heat_call,
  input  wire logic               pilot_continuous,
  input  wire logic               low_power_sw,
  // ignition module
  output logic                    ign_power,
  input  wire logic               ign_alarm,
  input  wire logic               ign_valve,
  // solenoids and display
  output ign_seq_pkg::sol_t       sol,
  output logic                    sol_low_power,
  output ign_seq_pkg::disp_code_t disp_code,
  // rs-485 transceiver
  input  wire logic               rs485_rx,
  output logic                    rs485_tx,
  output logic                    rs485_de
);
  import ign_seq_pkg::*;

  seq_state_t       state_r;
  logic [31:0]      tick_cnt_r;
  logic [31:0]      timer_r;
  logic             soft_stop_r;
  logic [INT_W-1:0] int_sts_r;
  logic [INT_W-1:0] int_mask_r;
  logic [7:0]       slave_addr_r;
  logic             all_perm_d_r;
  logic             closure_d_r;
  logic             alarm_d_r;
  logic             main_d_r;
  logic             all_perm;
  logic             permit;
  logic             heat_ok;
  logic             tick;
  logic [INT_W-1:0] ev;
  logic [31:0]      status_word;
  logic [31:0]      rd_mux;
  logic [2:0]       wsel;
  logic             wr_en;
  logic             rx_valid;
  logic [7:0]       rx_data;
  logic             tx_ready;
  logic [7:0]       mb_buf [RX_LEN];
  logic [3:0]       mb_cnt_r;
  logic [15:0]      mb_crc_r;
  logic [31:0]      sil_r;
  logic             frame_end;
  logic             frame_ok;
  logic             replying_r;
  logic [2:0]       tx_idx_r;
  logic [15:0]      tx_crc_r;
  logic [15:0]      rsp_word_r;
  logic [7:0]       tx_byte;

  function automatic logic [2:0] reg_index(input logic [11:0] a);
    if (a == OFS_CTRL) return 3'h0;
    else if (a == OFS_STATUS) return 3'h1;
    else if (a == OFS_INT_STS) return 3'h2;
    else if (a == OFS_INT_MASK) return 3'h3;
    else if (a == OFS_SLAVE_ADDR) return 3'h4;
    else return SEL_NONE;
  endfunction

  assign all_perm = &perm;
  assign permit   = all_perm && !soft_stop_r && !ign_alarm;
  assign heat_ok  = pilot_continuous || heat_call;
  assign tick     = (tick_cnt_r == TICK_CYCLES_P - 1);

  // fixed system tick
  always_ff @(posedge clk) begin
    if (!rstn || tick) tick_cnt_r <= 32'h0;
    else tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  // burner sequence
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= SEQ_IDLE;
      timer_r <= 32'h0;
    end else if (!permit || !heat_ok) begin
      state_r <= SEQ_IDLE;
      timer_r <= 32'h0;
    end else begin
      case (state_r)
        SEQ_IDLE: begin
          state_r <= SEQ_PILOT;
          timer_r <= 32'h0;
        end
        SEQ_PILOT: begin
          if (ign_valve) state_r <= SEQ_WAIT;
          timer_r <= 32'h0;
        end
        SEQ_WAIT: begin
          if (!ign_valve) begin
            state_r <= SEQ_PILOT;
            timer_r <= 32'h0;
          end else if (timer_r == MAIN_TICKS_P) begin
            if (heat_call) state_r <= SEQ_RUN;
          end else if (tick) begin
            timer_r <= timer_r + 32'h1;
          end
        end
        SEQ_RUN: begin
          if (!ign_valve) begin
            state_r <= SEQ_PILOT;
            timer_r <= 32'h0;
          end
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end

  // outputs to the module and the solenoids
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ign_power     <= 1'b0;
      sol           <= '0;
      sol_low_power <= 1'b0;
    end else begin
      ign_power     <= all_perm && !soft_stop_r;
      sol.pilot     <= permit && heat_ok && state_r != SEQ_IDLE;
      sol.main_v    <= permit && heat_ok && state_r == SEQ_RUN;
      sol.tmain     <= permit && heat_call && state_r == SEQ_RUN;
      sol_low_power <= low_power_sw;
    end
  end

  // display, closure-proof first
  always_ff @(posedge clk) begin
    if (!rstn) disp_code <= DISP_OFF;
    else if (!perm.closure_proof_switch) disp_code <= DISP_CLOSURE;
    else if (!perm.on_off) disp_code <= DISP_OFF;
    else if (!perm.remote_on) disp_code <= DISP_REMOTE;
    else if (!perm.level_ok) disp_code <= DISP_LEVEL;
    else if (!perm.shutdown_ok) disp_code <= DISP_SHUTDOWN;
    else if (!perm.temp1_ok || !perm.temp2_ok) disp_code <= DISP_TEMP;
    else if (ign_alarm) disp_code <= DISP_FLAME;
    else disp_code <= DISP_RUN;
  end

  // event edges
  always_ff @(posedge clk) begin
    if (!rstn) begin
      // no closure or shutdown edge until a closed input has been seen once
      all_perm_d_r <= 1'b0;
      closure_d_r  <= 1'b0;
      alarm_d_r    <= 1'b0;
      main_d_r     <= 1'b0;
    end else begin
      all_perm_d_r <= all_perm;
      closure_d_r  <= perm.closure_proof_switch;
      alarm_d_r    <= ign_alarm;
      main_d_r     <= sol.main_v;
    end
  end

  always_comb begin
    ev              = '0;
    ev[EV_CLOSURE]  = closure_d_r && !perm.closure_proof_switch;
    ev[EV_SHUTDOWN] = all_perm_d_r && !all_perm;
    ev[EV_ALARM]    = !alarm_d_r && ign_alarm;
    ev[EV_MAIN_ON]  = !main_d_r && sol.main_v;
    ev[EV_MB_REPLY] = frame_ok;
  end

  // apb register file
  assign wsel    = reg_index(paddr);
  assign wr_en   = psel && penable && pwrite && wsel != SEL_NONE;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && wsel == SEL_NONE;
  assign irq     = |(int_sts_r & int_mask_r);
  assign status_word = {14'h0000, state_r, disp_code, sol, ign_power,
                        ign_alarm, ign_valve, perm};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wsel)
      3'h0: rd_mux = {31'h0000_0000, soft_stop_r};
      3'h1: rd_mux = status_word;
      3'h2: rd_mux = {27'h000_0000, int_sts_r};
      3'h3: rd_mux = {27'h000_0000, int_mask_r};
      3'h4: rd_mux = {24'h00_0000, slave_addr_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) prdata <= 32'h0000_0000;
    else if (psel && !penable) prdata <= rd_mux;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_stop_r  <= 1'b0;
      int_mask_r   <= INT_MASK_RST;
      slave_addr_r <= DEF_SLAVE_ADDR;
    end else if (wr_en) begin
      if (wsel == 3'h0) soft_stop_r <= pwdata[0];
      if (wsel == 3'h3) int_mask_r <= pwdata[INT_W-1:0];
      if (wsel == 3'h4) slave_addr_r <= pwdata[7:0];
    end
  end

  // sticky status, set wins over write-one-clear
  always_ff @(posedge clk) begin
    if (!rstn) int_sts_r <= '0;
    else if (wr_en && wsel == 3'h2) int_sts_r <= (int_sts_r & ~pwdata[INT_W-1:0]) | ev;
    else int_sts_r <= int_sts_r | ev;
  end

  // modbus rtu framing
  uart_8n1 #(.DIV(BAUD_DIV_P)) u_uart (
    .clk      (clk),
    .rstn     (rstn),
    .rx_in    (rs485_rx),
    .tx_out   (rs485_tx),
    .tx_oe    (rs485_de),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_valid (replying_r),
    .tx_data  (tx_byte),
    .tx_ready (tx_ready)
  );

  assign frame_end = mb_cnt_r != 4'h0 && !rx_valid && sil_r == T35_CYCLES_P - 1;
  assign frame_ok  = frame_end && !replying_r && mb_cnt_r == RX_LEN
                     && mb_buf[0] == slave_addr_r && mb_buf[1] == MB_FN_READ
                     && mb_buf[4] == 8'h00 && mb_buf[5] == 8'h01 && mb_crc_r == 16'h0000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mb_cnt_r <= 4'h0;
      mb_crc_r <= 16'hFFFF;
      sil_r    <= 32'h0;
    end else if (rx_valid && !replying_r) begin
      if (mb_cnt_r < RX_LEN) mb_buf[mb_cnt_r[2:0]] <= rx_data;
      if (mb_cnt_r != 4'hF) mb_cnt_r <= mb_cnt_r + 4'h1;
      mb_crc_r <= crc16_byte(mb_crc_r, rx_data);
      sil_r    <= 32'h0;
    end else if (frame_end) begin
      mb_cnt_r <= 4'h0;
      mb_crc_r <= 16'hFFFF;
      sil_r    <= 32'h0;
    end else if (mb_cnt_r != 4'h0) begin
      sil_r <= sil_r + 32'h1;
    end
  end

  always_comb begin
    case (tx_idx_r)
      3'h0: tx_byte = slave_addr_r;
      3'h1: tx_byte = MB_FN_READ;
      3'h2: tx_byte = MB_RD_BYTES;
      3'h3: tx_byte = rsp_word_r[15:8];
      3'h4: tx_byte = rsp_word_r[7:0];
      3'h5: tx_byte = tx_crc_r[7:0];
      default: tx_byte = tx_crc_r[15:8];
    endcase
  end

  // reply only to a valid request
  always_ff @(posedge clk) begin
    if (!rstn) begin
      replying_r <= 1'b0;
      tx_idx_r   <= 3'h0;
      tx_crc_r   <= 16'hFFFF;
      rsp_word_r <= 16'h0000;
    end else if (frame_ok) begin
      replying_r <= 1'b1;
      tx_idx_r   <= 3'h0;
      tx_crc_r   <= 16'hFFFF;
      if ({mb_buf[2], mb_buf[3]} == 16'h0000) rsp_word_r <= status_word[15:0];
      else if ({mb_buf[2], mb_buf[3]} == 16'h0001) rsp_word_r <= {11'h000, int_sts_r};
      else rsp_word_r <= 16'h0000;
    end else if (replying_r && tx_ready) begin
      tx_idx_r <= tx_idx_r + 3'h1;
      if (tx_idx_r < TX_CRC_FIRST) tx_crc_r <= crc16_byte(tx_crc_r, tx_byte);
      if (tx_idx_r == TX_LAST) replying_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_cp_power;
    !perm.closure_proof_switch |=> !ign_power && !sol.pilot;
  endproperty
  a_cp_power: assert property (p_cp_power) else $error("power with closure open");

  property p_cp_idle;
    !perm.closure_proof_switch |=> state_r == SEQ_IDLE && timer_r == 32'h0;
  endproperty
  a_cp_idle: assert property (p_cp_idle) else $error("sequence ran with closure open");

  property p_cp_disp;
    !perm.closure_proof_switch |=> disp_code == DISP_CLOSURE;
  endproperty
  a_cp_disp: assert property (p_cp_disp) else $error("closure code not shown");

  property p_perm_power;
    ign_power |-> $past(all_perm) && !$past(soft_stop_r);
  endproperty
  a_perm_power: assert property (p_perm_power) else $error("power without permissives");

  property p_main_pilot;
    (sol.main_v || sol.tmain) |-> sol.pilot && ign_power;
  endproperty
  a_main_pilot: assert property (p_main_pilot) else $error("main on without pilot");

  property p_main_delay;
    $rose(sol.main_v) |-> $past(timer_r) == MAIN_TICKS_P && $past(ign_valve, 2);
  endproperty
  a_main_delay: assert property (p_main_delay) else $error("main on before delay");

  property p_tmain_heat;
    sol.tmain |-> $past(heat_call) && sol.main_v;
  endproperty
  a_tmain_heat: assert property (p_tmain_heat) else $error("tmain on without heat call");

  property p_low_power;
    ##1 sol_low_power == $past(low_power_sw);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power output stale");

  property p_intermittent;
    !pilot_continuous && !heat_call |=> !sol.pilot ##1 state_r == SEQ_IDLE || heat_call;
  endproperty
  a_intermittent: assert property (p_intermittent) else $error("pilot on without heat");

  property p_shutdown;
    !perm.level_ok || !perm.shutdown_ok |=> !ign_power && sol == '0;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("outputs on during shutdown");

  property p_timer_restart;
    state_r == SEQ_WAIT && !permit |=> timer_r == 32'h0;
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer kept after drop");

  property p_reply_cause;
    $rose(replying_r) |-> $past(frame_ok) ##[1:3] rs485_de;
  endproperty
  a_reply_cause: assert property (p_reply_cause) else $error("unsolicited reply");

  property p_addr_default;
    $rose(rstn) |-> slave_addr_r == DEF_SLAVE_ADDR;
  endproperty
  a_addr_default: assert property (p_addr_default) else $error("slave address not default");

  c_main_on:   cover property ($rose(sol.main_v));
  c_tmain_off: cover property (sol.main_v && $fell(sol.tmain));
  c_reply:     cover property (frame_ok);
  c_cp_drop:   cover property (state_r == SEQ_RUN && !perm.closure_proof_switch);
endmodule

// ==== verification/ign_module_model.sv ====
`timescale 1ns/10ps
module ign_module_model #(
  parameter int LIGHT_CYC = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // device side
  input  wire logic power,
  input  wire logic pilot,
  input  wire logic fail,
  output logic      alarm,
  output logic      valve
);
  int cnt;

  // flame proven a few cycles after pilot gas with power
  always_ff @(posedge clk) begin
    if (!rstn || !power || !pilot || fail) begin
      cnt <= 0;
    end else if (cnt < LIGHT_CYC) begin
      cnt <= cnt + 1;
    end
  end

  assign valve = power && !fail && (cnt >= LIGHT_CYC);
  assign alarm = power && fail;
endmodule

// ==== verification/burner_ignition_sequencer_tb.sv ====
`timescale 1ns/10ps
module burner_ignition_sequencer_tb;
  import ign_seq_pkg::*;
  localparam int TC = 10;
  localparam int MT = 5;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, err, ign_power, alarm, valve, tx, de;
  perm_t       perm = '0;
  logic        heat = 0, cont = 0, lp = 0, fail = 0, sol_lp, de_seen = 0, rx = 1;
  sol_t        sol;
  disp_code_t  disp;
  int          errors = 0, n_tests = 0, cyc = 0, k;

  burner_ignition_sequencer #(.MAIN_TICKS_P(MT), .TICK_CYCLES_P(TC), .BAUD_DIV_P(16),
    .T35_CYCLES_P(700)) DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .perm(perm), .heat_call(heat), .pilot_continuous(cont),
    .low_power_sw(lp), .ign_power(ign_power), .ign_alarm(alarm), .ign_valve(valve),
    .sol(sol), .sol_low_power(sol_lp), .disp_code(disp), .rs485_rx(rx),
    .rs485_tx(tx), .rs485_de(de));

  ign_module_model partner (.clk(clk), .rstn(rstn), .power(ign_power), .pilot(sol.pilot),
    .fail(fail), .alarm(alarm), .valve(valve));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (de === 1'b1) de_seen <= 1;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wait_valve();
    k = 0;
    while (valve !== 1'b1 && k < 100) begin
      cy(1);
      k++;
    end
  endtask

  task automatic t_reset();
    cy(4);
    chk(ign_power, 0, "power in reset");
    chk(sol, 0, "sol in reset");
    chk({tx, de}, 2'b10, "line idle in reset");
    @(posedge clk) rstn <= 1;
    apb(0, OFS_SLAVE_ADDR, 0);
    chk(rd[7:0], 8'h02, "slave address");
    apb(0, 12'h014, 0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    @(posedge clk) lp <= 1;
    cy(2);
    chk(sol_lp, 1, "low power copy");
  endtask

  task automatic t_start();
    @(posedge clk) begin perm <= '1; heat <= 1; end
    cy(1);
    chk({ign_power, sol}, 4'b1000, "power before pilot");
    cy(1);
    chk(sol, 3'b100, "pilot first");
    wait_valve();
    chk(sol, 3'b100, "mains off at flame");
    k = 0;
    while (sol.main_v !== 1'b1 && k < 200) begin
      cy(1);
      k++;
    end
    chk(k >= (MT - 1) * TC && k <= MT * TC + 10, 1, "main delay");
    chk(sol, 3'b111, "mains on");
  endtask

  task automatic t_closure();
    apb(1, OFS_INT_MASK, 32'h1);
    @(posedge clk) perm.closure_proof_switch <= 0;
    cy(2);
    chk({ign_power, sol}, 0, "closure open");
    chk(disp, DISP_CLOSURE, "closure code");
    chk(irq, 1, "closure irq");
    apb(1, OFS_INT_STS, 32'h1);
    cy(1);
    chk(irq, 0, "irq cleared");
    @(posedge clk) perm <= '1;
  endtask

  task automatic t_perm();
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) perm <= perm_t'(~(7'h01 << i));
      cy(2);
      chk({ign_power, sol}, 0, "permissive drop");
      @(posedge clk) perm <= '1;
      cy(2);
      chk(ign_power, 1, "permissive back");
    end
  endtask

  task automatic t_cont();
    @(posedge clk) begin heat <= 0; cont <= 1; end
    cy(3);
    chk(sol, 3'b100, "continuous pilot");
    wait_valve();
    cy(MT * TC + 10);
    chk(sol, 3'b100, "no mains without heat");
    @(posedge clk) heat <= 1;
    cy(4);
    chk(sol, 3'b111, "mains on heat");
    @(posedge clk) heat <= 0;
    cy(2);
    chk(sol, 3'b110, "setpoint drops tmain");
    @(posedge clk) fail <= 1;
    cy(3);
    chk({ign_power, sol}, 4'b1000, "alarm blocks");
    @(posedge clk) begin fail <= 0; cont <= 0; end
    cy(3);
    chk(sol, 0, "intermittent no heat");
    chk(de_seen, 0, "never talks first");
  endtask

  // modbus master side: 16 clocks per bit, as the bench divider
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction

  task automatic mb_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) rx <= f[i];
      repeat (15) @(posedge clk);
    end
  endtask

  task automatic mb_frame(input logic [7:0] a, input logic [7:0] r);
    logic [7:0]  f [8];
    logic [15:0] c;
    f = '{a, 8'h03, 8'h00, r, 8'h00, 8'h01, 8'h00, 8'h00};
    c = 16'hFFFF;
    for (int i = 0; i < 6; i++) c = crc(c, f[i]);
    f[6] = c[7:0];
    f[7] = c[15:8];
    for (int i = 0; i < 8; i++) mb_send(f[i]);
  endtask

  task automatic mb_recv(output logic [7:0] b);
    while (tx !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      b[i] = tx;
    end
    repeat (16) @(posedge clk);
    chk(tx, 1, "stop bit");
  endtask

  task automatic t_modbus();
    logic [7:0]  b;
    logic [15:0] c;
    mb_frame(8'h03, 8'h05);
    repeat (900) @(posedge clk);
    chk(de_seen, 0, "other address ignored");
    mb_frame(8'h02, 8'h05);
    c = 16'hFFFF;
    for (int i = 0; i < 7; i++) begin
      mb_recv(b);
      chk(b, i == 0 ? 8'h02 : i == 1 ? 8'h03 : i == 2 ? 8'h02 : i < 5 ? 8'h00 : i == 5 ? c[7:0] : c[15:8], "reply byte");
      if (i < 5) c = crc(c, b);
    end
    chk(de_seen, 1, "reply driven");
  endtask

  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    t_reset();
    t_start();
    t_closure();
    t_perm();
    t_cont();
    t_modbus();
    final_report();
  end
endmodule
